//--- cfic_pkg.sv
// Purpose: shared constants and carriers for the flag, block i/o and interrupt core
// Assumes: single clock pclk, asynchronous active-low reset presetn
// Notes:   register offsets are byte addresses on a 32-bit apb bus
// Function
// - block i/o step decrements counter, sets null
// - repeating forms update null only at finish
// - add sets flags, overflow, clears subtract flag
// - subtract family sets subtract flag, overflow
// - 16-bit subtract-with-carry (core: 8-bit, on the high pointer byte only); nibble-carry undefined
// - rotate/shift: parity, clear nibble/subtract, msb-out
// - vector/refresh load copies saved enable flag
// - bit test: null from bit, nibble-carry set
// - negative flag equals result msb
// - parity flag one for even ones
// - nibble-carry from carry/borrow at bit 4
// - msb-out from carry out of msb
// - principal and alternate register sets, exchanged
// - non-maskable request always accepted, top priority
// - maskable request gated by enable, three modes (core: mode bits stored only, same acknowledge-only response in every mode)
// - requests sampled at final instruction clock
// - one automatic wait in every i/o cycle
// - non-maskable response ignores data, restarts 0066h
// - stopped clock keeps registers and outputs
package cfic_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CFIC_OFS_CMD    = 8'h00;  // operation, operands, start
  localparam logic [7:0] CFIC_OFS_RESULT = 8'h04;  // result and flags
  localparam logic [7:0] CFIC_OFS_REGS   = 8'h08;  // accumulator, loop count, port low
  localparam logic [7:0] CFIC_OFS_PTR    = 8'h0C;  // memory pointer pair
  localparam logic [7:0] CFIC_OFS_INT    = 8'h10;  // interrupt control
  localparam logic [7:0] CFIC_OFS_STAT   = 8'h14;  // status
  localparam logic [7:0] CFIC_OFS_IODATA = 8'h18;  // byte moved by block i/o
  localparam logic [7:0] CFIC_OFS_RSTRT  = 8'h1C;  // restart address

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFIC_CMD_START_BIT = 31;          // write one to start
  localparam int CFIC_FLG_NEG  = 7;                // negative
  localparam int CFIC_FLG_NULL = 6;                // null result
  localparam int CFIC_FLG_NIB  = 4;                // nibble carry
  localparam int CFIC_FLG_PV   = 2;                // parity / overflow
  localparam int CFIC_FLG_SUB  = 1;                // subtract operation
  localparam int CFIC_FLG_MSB  = 0;                // msb out
  localparam int CFIC_INT_EN   = 0;                // interrupt enable
  localparam int CFIC_INT_SAVE = 1;                // saved_enable_flipflop
  localparam int CFIC_INT_MODE = 2;                // two mode bits

  // ----------------------------------------------------------------
  // values and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] CFIC_NMI_RESTART = 16'h0066;  // restart address
  localparam logic [3:0]  CFIC_IO_WAITS    = 4'h1;      // automatic i/o waits
  localparam logic [3:0]  CFIC_MC_REPEAT   = 4'h5;      // cycles, nonfinal pass
  localparam logic [3:0]  CFIC_MC_FINAL    = 4'h4;      // cycles, final pass
  localparam logic [7:0]  CFIC_RESET_BYTE  = 8'h00;     // register reset value
  localparam logic [1:0]  CFIC_MODE_VECT   = 2'h2;      // vectored daisy chain

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CFIC_OP_ADD  = 4'h0, CFIC_OP_ADC  = 4'h1, CFIC_OP_SUB  = 4'h2,
    CFIC_OP_SBC  = 4'h3, CFIC_OP_CMP  = 4'h4, CFIC_OP_NEG  = 4'h5,
    CFIC_OP_SBCW = 4'h6, CFIC_OP_ROT  = 4'h7, CFIC_OP_LDIV = 4'h8,
    CFIC_OP_BIT  = 4'h9, CFIC_OP_BLK  = 4'hA, CFIC_OP_EXX  = 4'hB,
    CFIC_OP_EI   = 4'hC, CFIC_OP_DI   = 4'hD, CFIC_OP_RETURN_FROM_NONMASKABLE = 4'hE,
    CFIC_OP_HALT = 4'hF
  } cfic_op_t;

  // 8-bit flag calculation carrier
  typedef struct packed {
    logic [7:0] res;   // result byte
    logic [7:0] flg;   // flag byte
  } cfic_alu_t;

endpackage

//--- cfic_alu.sv
// Purpose: flag generation for arithmetic, rotate, bit test and vector loads
// Assumes: pure combinational, called once per started operation
// Notes:   undefined flag bits are left at their previous value
`timescale 1ns/1ps
`default_nettype none
module cfic_alu (
  input  wire logic [3:0]        op,
  input  wire logic [7:0]        a,
  input  wire logic [7:0]        b,
  input  wire logic [2:0]        sel,
  input  wire logic [7:0]        fin,
  input  wire logic              save_en,
  output cfic_pkg::cfic_alu_t    out
);

  // ----------------------------------------------------------------
  // arithmetic core
  // ----------------------------------------------------------------
  logic [8:0] sum;     // 9-bit sum or difference
  logic [4:0] nib;     // low nibble sum
  logic       cin;     // carry in
  logic       sub;     // subtract family
  logic       ovf;     // signed overflow
  logic [7:0] x;       // left operand
  logic [7:0] y;       // right operand

  // computes result and flags per operation
  always_comb begin
    out = '{res: a, flg: fin};
    cin = 1'b0;
    sub = 1'b0;
    x   = a;
    y   = b;
    unique case (op)
      cfic_pkg::CFIC_OP_ADC:  cin = fin[cfic_pkg::CFIC_FLG_MSB];
      cfic_pkg::CFIC_OP_SUB,
      cfic_pkg::CFIC_OP_CMP:  sub = 1'b1;
      cfic_pkg::CFIC_OP_SBC,
      cfic_pkg::CFIC_OP_SBCW: begin
        sub = 1'b1;
        cin = fin[cfic_pkg::CFIC_FLG_MSB];
      end
      cfic_pkg::CFIC_OP_NEG: begin
        sub = 1'b1;
        x   = 8'h00;
        y   = a;
      end
      default: ;
    endcase
    if (sub) begin
      sum = {1'b0, x} - {1'b0, y} - {8'h00, cin};
      nib = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
      ovf = (x[7] != y[7]) && (sum[7] != x[7]);
    end else begin
      sum = {1'b0, x} + {1'b0, y} + {8'h00, cin};
      nib = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
      ovf = (x[7] == y[7]) && (sum[7] != x[7]);
    end
    unique case (op)
      cfic_pkg::CFIC_OP_ADD, cfic_pkg::CFIC_OP_ADC,
      cfic_pkg::CFIC_OP_SUB, cfic_pkg::CFIC_OP_SBC,
      cfic_pkg::CFIC_OP_CMP, cfic_pkg::CFIC_OP_NEG: begin
        if (op != cfic_pkg::CFIC_OP_CMP) out.res = sum[7:0];
        out.flg[cfic_pkg::CFIC_FLG_NEG]  = sum[7];
        out.flg[cfic_pkg::CFIC_FLG_NULL] = (sum[7:0] == 8'h00);
        out.flg[cfic_pkg::CFIC_FLG_NIB]  = nib[4];
        out.flg[cfic_pkg::CFIC_FLG_PV]   = ovf;
        out.flg[cfic_pkg::CFIC_FLG_SUB]  = sub;
        out.flg[cfic_pkg::CFIC_FLG_MSB]  = sum[8];
      end
      cfic_pkg::CFIC_OP_SBCW: begin
        // high byte of the pointer pair; nibble carry left as is
        out.res = sum[7:0];
        out.flg[cfic_pkg::CFIC_FLG_NEG]  = sum[7];
        out.flg[cfic_pkg::CFIC_FLG_NULL] = (sum[7:0] == 8'h00);
        out.flg[cfic_pkg::CFIC_FLG_PV]   = ovf;
        out.flg[cfic_pkg::CFIC_FLG_SUB]  = 1'b1;
        out.flg[cfic_pkg::CFIC_FLG_MSB]  = sum[8];
      end
      cfic_pkg::CFIC_OP_ROT: begin
        // rotate left circular; msb leaves into msb-out
        out.res = {a[6:0], a[7]};
        out.flg[cfic_pkg::CFIC_FLG_NEG]  = a[6];
        out.flg[cfic_pkg::CFIC_FLG_NULL] = (a == 8'h00);
        out.flg[cfic_pkg::CFIC_FLG_PV]   = ~(^a);
        out.flg[cfic_pkg::CFIC_FLG_NIB]  = 1'b0;
        out.flg[cfic_pkg::CFIC_FLG_SUB]  = 1'b0;
        out.flg[cfic_pkg::CFIC_FLG_MSB]  = a[7];
      end
      cfic_pkg::CFIC_OP_LDIV: begin
        // accumulator takes the vector/refresh byte
        out.res = b;
        out.flg[cfic_pkg::CFIC_FLG_NEG]  = b[7];
        out.flg[cfic_pkg::CFIC_FLG_NULL] = (b == 8'h00);
        out.flg[cfic_pkg::CFIC_FLG_PV]   = save_en;
        out.flg[cfic_pkg::CFIC_FLG_NIB]  = 1'b0;
        out.flg[cfic_pkg::CFIC_FLG_SUB]  = 1'b0;
      end
      cfic_pkg::CFIC_OP_BIT: begin
        // null flag set when selected bit is zero; msb-out kept
        out.flg[cfic_pkg::CFIC_FLG_NULL] = ~b[sel];
        out.flg[cfic_pkg::CFIC_FLG_NIB]  = 1'b1;
        out.flg[cfic_pkg::CFIC_FLG_SUB]  = 1'b0;
      end
      default: ;
    endcase
  end

endmodule
`default_nettype wire

//--- cfic_core.sv
// Purpose: apb-controlled flag, block i/o and interrupt core
// Assumes: all inputs except the asynchronous reset presetn synchronous to pclk
// Notes:   i/o and memory cycles run as one-beat external strobes
`timescale 1ns/1ps
`default_nettype none
module cfic_core (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         nmi_req_n,
  input  wire logic         int_req_n,
  input  wire logic [7:0]   io_rdata,
  output logic      [15:0]  io_addr,
  output logic      [7:0]   io_wdata,
  output logic              io_rd,
  output logic              io_wr,
  output logic              io_wait,
  output logic      [15:0]  mem_addr,
  output logic              mem_rd,
  output logic              nmi_ack,
  output logic              int_ack,
  output logic              halted
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CFIC_ST_IDLE = 3'b000,   // waiting for a command
    CFIC_ST_IOA  = 3'b001,   // i/o address phase
    CFIC_ST_IOW  = 3'b010,   // automatic wait
    CFIC_ST_IOD  = 3'b011,   // i/o data phase
    CFIC_ST_REP  = 3'b100,   // extra cycles of a pass
    CFIC_ST_NMI  = 3'b101,   // non-maskable response read
    CFIC_ST_HALT = 3'b110    // halted, clock may be stopped
  } cfic_st_t;

  typedef struct packed {
    cfic_st_t    st;         // sequencer state
    logic [7:0]  acc;        // accumulator
    logic [7:0]  flg;        // flags
    logic [7:0]  cnt;        // loop counter
    logic [7:0]  plo;        // port-low register
    logic [15:0] ptr;        // memory_pointer_pair
    logic [47:0] gen;        // other general registers
    logic [63:0] alt;        // alternate acc, flags, six registers
    logic [7:0]  iob;        // byte moved by block i/o
    logic [31:0] cmd;        // last command word
    logic        ien;        // interrupt enable
    logic        sav;        // saved_enable_flipflop
    logic [1:0]  mode;       // maskable response mode
    logic [15:0] pc;         // restart address
    logic [3:0]  mc;         // pass cycle count
    logic        dirout;     // block output direction
    logic        down;       // step pointer down
    logic        rpt;        // repeating form
    logic        nmi_seen;   // sticky restart indication
    logic        int_seen;   // sticky maskable indication
    logic [31:0] rd;         // read data
    logic        rdy;        // pready
    logic [15:0] ioa;        // io_addr
    logic [7:0]  iow;        // io_wdata
    logic        iord;       // io_rd
    logic        iowr;       // io_wr
    logic        iowt;       // io_wait
    logic        mrd;        // mem_rd
    logic        nack;       // nmi_ack
    logic        iack;       // int_ack
    logic        hlt;        // halted
  } cfic_state_t;

  cfic_state_t s_q;          // registered state
  cfic_state_t s_d;          // next state
  cfic_pkg::cfic_alu_t alu;  // flag unit output
  logic        acc_wr;       // apb write access
  logic        acc_rd;       // apb read access
  logic        start;        // command start
  logic        fin_instr;    // final clock of an instruction

  localparam int CFIC_PENDING_BIT = 28;   // alu result still to be written

  // ----------------------------------------------------------------
  // flag unit
  // ----------------------------------------------------------------
  cfic_alu u_alu (
    .op      (s_q.cmd[27:24]),
    .a       ((s_q.cmd[27:24] == cfic_pkg::CFIC_OP_SBCW) ? s_q.ptr[15:8] : s_q.acc),
    .b       (s_q.cmd[7:0]),
    .sel     (s_q.cmd[10:8]),
    .fin     (s_q.flg),
    .save_en (s_q.sav),
    .out     (alu)
  );

  // writes land on the edge at which the master sees pready high
  assign acc_wr    = psel && penable && pwrite && s_q.rdy;
  assign acc_rd    = psel && penable && !pwrite && !s_q.rdy;
  assign start     = acc_wr && (paddr == cfic_pkg::CFIC_OFS_CMD) &&
                     pwdata[cfic_pkg::CFIC_CMD_START_BIT];
  assign fin_instr = (s_q.st == CFIC_ST_IDLE) || (s_q.st == CFIC_ST_HALT);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.rdy  = psel && penable && !s_q.rdy;
    s_d.iord = 1'b0;
    s_d.iowr = 1'b0;
    s_d.iowt = 1'b0;
    s_d.mrd  = 1'b0;
    s_d.nack = 1'b0;
    s_d.iack = 1'b0;
    // read mux
    if (acc_rd) begin
      unique case (paddr)
        cfic_pkg::CFIC_OFS_CMD:    s_d.rd = s_q.cmd;
        cfic_pkg::CFIC_OFS_RESULT: s_d.rd = {16'h0000, s_q.flg, s_q.acc};
        cfic_pkg::CFIC_OFS_REGS:   s_d.rd = {8'h00, s_q.plo, s_q.cnt, s_q.acc};
        cfic_pkg::CFIC_OFS_PTR:    s_d.rd = {16'h0000, s_q.ptr};
        cfic_pkg::CFIC_OFS_INT:    s_d.rd = {28'h000_0000, s_q.mode, s_q.sav, s_q.ien};
        cfic_pkg::CFIC_OFS_STAT:   s_d.rd = {24'h00_0000, s_q.int_seen, s_q.nmi_seen,
                                             2'b00, 1'b0, s_q.st};
        cfic_pkg::CFIC_OFS_IODATA: s_d.rd = {24'h00_0000, s_q.iob};
        cfic_pkg::CFIC_OFS_RSTRT:  s_d.rd = {16'h0000, s_q.pc};
        default:                   s_d.rd = 32'h0000_0000;
      endcase
    end
    // plain register writes, only while idle
    if (acc_wr && s_q.st == CFIC_ST_IDLE) begin
      unique case (paddr)
        cfic_pkg::CFIC_OFS_RESULT: begin
          s_d.acc = pwdata[7:0];
          s_d.flg = pwdata[15:8];
        end
        cfic_pkg::CFIC_OFS_REGS: begin
          s_d.acc = pwdata[7:0];
          s_d.cnt = pwdata[15:8];
          s_d.plo = pwdata[23:16];
        end
        cfic_pkg::CFIC_OFS_PTR:    s_d.ptr = pwdata[15:0];
        cfic_pkg::CFIC_OFS_INT:    s_d.mode = pwdata[cfic_pkg::CFIC_INT_MODE +: 2];
        cfic_pkg::CFIC_OFS_IODATA: s_d.iob = pwdata[7:0];
        cfic_pkg::CFIC_OFS_STAT: begin
          // write one clears; a new event in the same cycle wins below
          if (pwdata[7]) s_d.int_seen = 1'b0;
          if (pwdata[6]) s_d.nmi_seen = 1'b0;
        end
        default: ;
      endcase
    end
    unique case (s_q.st)
      CFIC_ST_IDLE: begin
        if (start) begin
          s_d.cmd = pwdata;
          unique case (pwdata[27:24])
            cfic_pkg::CFIC_OP_BLK: begin
              s_d.dirout = pwdata[16];
              s_d.down   = pwdata[17];
              s_d.rpt    = pwdata[18];
              s_d.mc     = 4'h0;
              s_d.st     = CFIC_ST_IOA;
            end
            cfic_pkg::CFIC_OP_EXX: begin
              // accumulator, flags and the six other general registers change places; counter, port low and pointer stay
              s_d.alt = {s_q.acc, s_q.flg, s_q.gen};
              {s_d.acc, s_d.flg, s_d.gen} = s_q.alt;
            end
            cfic_pkg::CFIC_OP_EI: begin
              s_d.ien = 1'b1;
              s_d.sav = 1'b1;
            end
            cfic_pkg::CFIC_OP_DI: begin
              s_d.ien = 1'b0;
              s_d.sav = 1'b0;
            end
            cfic_pkg::CFIC_OP_RETURN_FROM_NONMASKABLE: s_d.ien = s_q.sav;
            cfic_pkg::CFIC_OP_HALT: s_d.st = CFIC_ST_HALT;
            default: ;
          endcase
        end else if (s_q.cmd[CFIC_PENDING_BIT]) begin
          // alu ops complete one cycle after the command
          s_d.acc = alu.res;
          s_d.flg = alu.flg;
          if (s_q.cmd[27:24] == cfic_pkg::CFIC_OP_SBCW) s_d.ptr[15:8] = alu.res;
          s_d.cmd[CFIC_PENDING_BIT] = 1'b0;
        end
      end
      CFIC_ST_IOA: begin
        // port address: counter high, port low low
        s_d.ioa = {s_q.cnt, s_q.plo};
        s_d.iow = s_q.iob;
        s_d.mc  = s_q.mc + 4'h1;
        // wait strobe stands while the sequencer sits in the wait state
        s_d.iowt = 1'b1;
        s_d.st  = CFIC_ST_IOW;
      end
      CFIC_ST_IOW: begin
        // raise the strobe so it stands through the data phase
        s_d.iord = !s_q.dirout;
        s_d.iowr = s_q.dirout;
        s_d.mc   = s_q.mc + cfic_pkg::CFIC_IO_WAITS;
        s_d.st   = CFIC_ST_IOD;
      end
      CFIC_ST_IOD: begin
        // input byte taken while the read strobe stands
        if (!s_q.dirout) s_d.iob = io_rdata;
        s_d.ptr = s_q.down ? s_q.ptr - 16'h0001 : s_q.ptr + 16'h0001;
        s_d.cnt = s_q.cnt - 8'h01;
        s_d.mc  = s_q.mc + 4'h1;
        // repeating forms set null only at the end
        if (!s_q.rpt || s_q.cnt == 8'h01)
          s_d.flg[cfic_pkg::CFIC_FLG_NULL] = (s_q.cnt == 8'h01);
        s_d.flg[cfic_pkg::CFIC_FLG_SUB] = 1'b1;
        s_d.st = CFIC_ST_REP;
      end
      CFIC_ST_REP: begin
        // pad each pass to its machine-cycle count
        s_d.mc = s_q.mc + 4'h1;
        if (s_q.rpt && s_q.cnt != 8'h00) begin
          if (s_q.mc + 4'h1 >= cfic_pkg::CFIC_MC_REPEAT) begin
            s_d.mc = 4'h0;
            s_d.st = CFIC_ST_IOA;
          end
        end else if (s_q.mc + 4'h1 >= cfic_pkg::CFIC_MC_FINAL) begin
          s_d.st = CFIC_ST_IDLE;
        end
      end
      CFIC_ST_NMI: begin
        // read-like cycle, data ignored, execution restarts
        s_d.mrd = 1'b1;
        s_d.pc  = cfic_pkg::CFIC_NMI_RESTART;
        s_d.st  = CFIC_ST_IDLE;
      end
      CFIC_ST_HALT: ;
      default: s_d.st = CFIC_ST_IDLE;
    endcase
    // interrupt sampling at the final clock of an instruction
    if (fin_instr && !start) begin
      if (!nmi_req_n) begin
        s_d.ien      = 1'b0;
        s_d.nack     = 1'b1;
        s_d.nmi_seen = 1'b1;
        s_d.st       = CFIC_ST_NMI;
      end else if (!int_req_n && s_q.ien) begin
        s_d.ien      = 1'b0;
        s_d.sav      = 1'b0;
        s_d.iack     = 1'b1;
        s_d.int_seen = 1'b1;
        s_d.st       = CFIC_ST_IDLE;
      end
    end
    // halted level registered so the port comes from a flip-flop
    s_d.hlt = (s_d.st == CFIC_ST_HALT);
  end

  // ----------------------------------------------------------------
  // registers; a stopped pclk freezes everything in place
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops except pslverr, tied low
  // ----------------------------------------------------------------
  assign prdata   = s_q.rd;
  assign pready   = s_q.rdy;
  assign pslverr  = 1'b0;
  assign io_addr  = s_q.ioa;
  assign io_wdata = s_q.iow;
  assign io_rd    = s_q.iord;
  assign io_wr    = s_q.iowr;
  assign io_wait  = s_q.iowt;
  assign mem_addr = s_q.pc;
  assign mem_rd   = s_q.mrd;
  assign nmi_ack  = s_q.nack;
  assign int_ack  = s_q.iack;
  assign halted   = s_q.hlt;

endmodule
`default_nettype wire

//--- cfic_core_asserts.sv
// Purpose: port checks for the flag, block i/o and interrupt core
// Assumes: one clock pclk, asynchronous active-low presetn
// Notes:   bound to cfic_core from the testbench top
`timescale 1ns/1ps
`default_nettype none
module cfic_core_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic        io_wait,
  input wire logic        mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic        nmi_ack,
  input wire logic        int_ack
);
  // ---------------------------------------------------------------
  // checks, all in the pclk domain
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_WAIT_THEN_STROBE: assert property (io_wait |=> (io_rd || io_wr))
    else $error("io wait not followed by a strobe");
  AST_WAIT_SINGLE: assert property (io_wait |=> !io_wait)
    else $error("more than one io wait");
  AST_STROBE_AFTER_WAIT: assert property ((io_rd || io_wr) |-> $past(io_wait))
    else $error("io strobe without a wait before it");
  AST_NMI_RESTART: assert property (mem_rd |-> ##[0:3] (mem_addr == 16'h0066))
    else $error("restart address wrong");
  AST_ACK_EXCLUSIVE: assert property (!(nmi_ack && int_ack))
    else $error("both requests acknowledged together");
  AST_APB_LATENCY: assert property ((psel && !penable) |-> ##2 pready)
    else $error("apb answer late");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_NO_SLVERR: assert property ($rose(psel) |-> !pslverr [*3])
    else $error("unexpected slave error");
endmodule
`default_nettype wire

//--- cfic_far_model.sv
// Purpose: io port and interrupt sources beside the core
// Assumes: requests fired by the bench, released on acknowledge
// Notes:   io read byte is port low xor counter byte
`timescale 1ns/1ps
`default_nettype none
module cfic_far_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        io_rd,
  input  wire logic [15:0] io_addr,
  input  wire logic        nmi_ack,
  input  wire logic        int_ack,
  input  wire logic        nmi_fire,
  input  wire logic        int_fire,
  output var  logic [7:0]  io_rdata,
  output var  logic        nmi_req_n,
  output var  logic        int_req_n
);
  logic [7:0] last_q;  // last byte driven
  // port answers only in the data phase, otherwise the inverse of the last byte
  always_comb io_rdata = io_rd ? (io_addr[7:0] ^ io_addr[15:8]) : ~last_q;
  // requests held low from well before the last state until acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_req_n <= 1'b1;
      int_req_n <= 1'b1;
      last_q    <= 8'h00;
    end else begin
      if (io_rd) last_q <= io_rdata;
      if (nmi_fire) nmi_req_n <= 1'b0;
      else if (nmi_ack) nmi_req_n <= 1'b1;
      if (int_fire) int_req_n <= 1'b0;
      else if (int_ack) int_req_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- cfic_core_tb_top.sv
// Purpose: self-checking bench for cfic_core
// Assumes: apb master, far model drives io and requests
// Notes:   table of flag cases, then block i/o and interrupts
`timescale 1ns/1ps
`default_nettype none
module cfic_core_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, io_rdata, io_wdata, seen_wdata;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, nmi_req_n, int_req_n, io_rd, io_wr, io_wait, mem_rd, halted;
  logic nmi_ack, int_ack, nmi_fire = 1'b0, int_fire = 1'b0;
  logic [15:0] io_addr, mem_addr, seen_addr;
  int failures = 0, comparisons = 0, cyc = 0, nwr = 0, iack = 0, n0;
  typedef struct packed {logic [3:0] op; logic [7:0] acc; logic [10:0] opd;
                         logic [15:0] msk; logic [15:0] exp;} cfic_row_t;
  cfic_row_t rows [11] = '{
    '{4'h0, 8'h7F, 11'h001, 16'hD7FF, 16'h9480}, '{4'h1, 8'hFF, 11'h001, 16'hD7FF, 16'h5100},
    '{4'h2, 8'h10, 11'h001, 16'hD7FF, 16'h120F}, '{4'h3, 8'h80, 11'h001, 16'hD7FF, 16'h167F},
    '{4'h4, 8'h01, 11'h002, 16'hD7FF, 16'h9301}, '{4'h5, 8'h01, 11'h000, 16'hD7FF, 16'h93FF},
    '{4'h7, 8'h81, 11'h081, 16'hD7FF, 16'h0503}, '{4'hC, 8'h00, 11'h000, 16'hD7FF, 16'h0500},
    '{4'h8, 8'h00, 11'h000, 16'h1600, 16'h0400}, '{4'h9, 8'h00, 11'h308, 16'h5300, 16'h1100},
    '{4'h6, 8'h00, 11'h001, 16'hC700, 16'h8300}};
  always #2 pclk = ~pclk;
  cfic_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .nmi_req_n, .int_req_n, .io_rdata, .io_addr, .io_wdata, .io_rd,
    .io_wr, .io_wait, .mem_addr, .mem_rd, .nmi_ack, .int_ack, .halted);
  cfic_far_model far (.pclk, .presetn, .io_rd, .io_addr, .nmi_ack, .int_ack, .nmi_fire,
    .int_fire, .io_rdata, .nmi_req_n, .int_req_n);
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready, one idle edge after
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic idle();
    do apb(1'b0, 8'h14, 32'h0); while (q[2:0] !== 3'b000);
  endtask
  task automatic conclude();
    if (failures == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // event counters and the hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (io_rd) seen_addr <= io_addr;
    if (io_wr) nwr <= nwr + 1;
    if (io_wr) seen_wdata <= io_wdata;
    if (int_ack) iack <= iack + 1;
    if (cyc == 30000) begin
      failures++;
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    chk("reset outputs", 32'({io_rd, io_wr, io_wait, mem_rd, nmi_ack, int_ack, pready, halted}), 0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    chk("regs reset", q, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, 8'h08, 32'(rows[i].acc));
      apb(1'b1, 8'h00, {1'b1, 2'b00, rows[i].op <= 4'h9, rows[i].op, 13'h0, rows[i].opd});
      idle();
      apb(1'b0, 8'h04, 32'h0);
      chk("flags", 32'(q[15:0] & rows[i].msk), 32'(rows[i].exp));
    end
    apb(1'b1, 8'h04, 32'h0000_A55A);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 8'h00, 32'h8B00_0000);
      idle();
      apb(1'b0, 8'h04, 32'h0);
      chk("register set", q, i ? 32'h0000_A55A : 32'h0000_0000);
    end
    apb(1'b1, 8'h10, 32'h0000_0008);
    apb(1'b0, 8'h10, 32'h0);
    chk("mode and enables", q, 32'h0000_000B);
    apb(1'b1, 8'h0C, 32'h0000_1000);
    apb(1'b1, 8'h08, 32'h0034_0200);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 8'h00, 32'h8A00_0000);
      idle();
      chk("port address", 32'(seen_addr), {16'h0, 8'(2 - i), 8'h34});
      apb(1'b0, 8'h08, 32'h0);
      chk("counter", 32'(q[23:8]), {16'h0, 8'h34, 8'(1 - i)});
      apb(1'b0, 8'h04, 32'h0);
      chk("null flag", 32'(q[14]), 32'(i));
      apb(1'b0, 8'h0C, 32'h0);
      chk("pointer", q, 32'h1001 + 32'(i));
      apb(1'b0, 8'h18, 32'h0);
      chk("input byte", 32'(q[7:0]), 32'(8'h34 ^ 8'(2 - i)));
    end
    apb(1'b1, 8'h04, 32'h0000_4000);
    apb(1'b1, 8'h08, 32'h0034_0300);
    n0 = nwr;
    apb(1'b1, 8'h00, 32'h8A07_0000);
    apb(1'b0, 8'h14, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk("null held mid-run", 32'(q[14]), 1);
    idle();
    chk("output byte", 32'(seen_wdata), 32'h0000_0035);
    chk("repeat strobes", 32'(nwr - n0), 3);
    apb(1'b0, 8'h0C, 32'h0);
    chk("pointer down", q, 32'h0000_0FFF);
    apb(1'b0, 8'h04, 32'h0);
    chk("null at finish", 32'(q[14]), 1);
    nmi_fire <= 1'b1; int_fire <= 1'b1;
    @(posedge pclk);
    nmi_fire <= 1'b0; int_fire <= 1'b0;
    repeat (30) @(posedge pclk);
    chk("int masked during nmi", iack, 0);
    apb(1'b0, 8'h1C, 32'h0);
    chk("restart address", q, 32'h0000_0066);
    apb(1'b1, 8'h00, 32'h8E00_0000);
    idle();
    repeat (30) @(posedge pclk);
    chk("int after return", iack, 1);
    apb(1'b1, 8'h00, 32'h8F00_0000);
    chk("halted", 32'(halted), 1);
    nmi_fire <= 1'b1;
    @(posedge pclk);
    nmi_fire <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("halt released", 32'(halted), 0);
    conclude();
  end
endmodule
bind cfic_core cfic_core_asserts chk_i (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .io_rd, .io_wr, .io_wait, .mem_rd, .mem_addr, .nmi_ack, .int_ack);
`default_nettype wire
